/* logic/msd_decode.sv */
// Memory space decoder: program fetch, data RAM, special registers, bits
`include "msd_params.svh"
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module msd_decode (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Program side
   input wire msd_pkg::msd_creq_s creq_i,
   input wire logic [7:0] acc_i,
   input wire logic [15:0] data_pointer_16_i,
   output logic [12:0] code_addr_o,
   output logic code_rd_o,
   // Data side
   input wire msd_pkg::msd_dreq_s dreq_i,
   input wire logic [2:0] bit_sel_i,
   input wire logic xdata_req_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   output logic bit_rdata_o,
   output logic sfr_sel_o,
   output logic sfr_we_o,
   output logic [7:0] sfr_addr_o,
   output logic [7:0] sfr_wdata_o,
   input wire logic [7:0] sfr_rdata_i,
   output logic xdata_nack_o,
   output logic [1:0] bank_o
);
   logic [7:0] status_reg;
   logic boot_reg;
   logic [15:0] cpc;
   logic [7:0] ram_addr;
   logic ram_we;
   logic [7:0] ram_wdata;
   logic [7:0] ram_rdata;
   logic to_sfr;
   logic to_ram;
   logic sfr_bit_ok;
   logic sfr_hit_reg;
   logic [2:0] bitpos_reg;
   logic bitmode_reg;
   logic [12:0] fetch_addr;
   logic [7:0] reg_addr;

   ////////////////////////////////////////////////////////////////////////////
   // Program space

   // Vector slot is reset vector plus 3 plus 8 times source
   always_comb begin
      if (creq_i.is_int) begin
         cpc = `MSD_VEC_EXT0 + `MSD_VEC_SPACING * {14'h0000, creq_i.int_src};
      end else if (creq_i.is_indexed) begin
         cpc = data_pointer_16_i + {8'h00, acc_i};
      end else begin
         cpc = creq_i.addr;
      end
   end

   // Reset vector wins only when the first fetch after reset is a plain one; vectors and table reads pass
   always_comb begin
      // Wraps inside 8K; no write path exists
      fetch_addr = cpc[12:0] & 13'(`MSD_CODE_MASK);
      if (boot_reg & ~creq_i.is_int & ~creq_i.is_indexed) begin
         fetch_addr = 13'(`MSD_RESET_VECTOR);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         boot_reg <= 1'b1;
         code_addr_o <= 13'h0000;
         code_rd_o <= 1'b0;
      end else begin
         // A plain first fetch after reset is forced to the reset vector
         boot_reg <= boot_reg & ~creq_i.valid;
         // Every fetch is served on chip; no external strobe exists
         code_rd_o <= creq_i.valid;
         if (creq_i.valid) begin
            code_addr_o <= fetch_addr;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data space routing

   // Register banks sit in the lowest 32 bytes, bank bits from the status shadow
   assign reg_addr = {3'b000, status_reg[`MSD_BANK_HI_POS], status_reg[`MSD_BANK_LO_POS],
      dreq_i.addr[2:0]};

   // 80H-FFH holds two spaces; only the mode tells them apart
   always_comb begin
      to_sfr = 1'b0;
      to_ram = 1'b0;
      ram_addr = dreq_i.addr;
      sfr_bit_ok = 1'b0;
      case (dreq_i.mode)
         msd_pkg::MSD_MODE_DIRECT: begin
            to_sfr = dreq_i.addr > `MSD_LOW_TOP;
            to_ram = ~to_sfr;
         end
         msd_pkg::MSD_MODE_INDIRECT: begin
            to_ram = 1'b1;
         end
         msd_pkg::MSD_MODE_REGISTER: begin
            to_ram = 1'b1;
            ram_addr = reg_addr;
         end
         msd_pkg::MSD_MODE_BIT: begin
            if (dreq_i.addr > `MSD_LOW_TOP) begin
               // Bit in an aligned special register byte
               // Unaligned ones hit nothing and raise no rvalid
               sfr_bit_ok = (dreq_i.addr & `MSD_SFR_BITADR_MASK) == 8'h00;
               to_sfr = sfr_bit_ok;
            end else begin
               to_ram = 1'b1;
               ram_addr = `MSD_BIT_BASE + {4'h0, dreq_i.addr[6:3]};
            end
         end
         default: begin
            to_ram = 1'b0;
         end
      endcase
   end

   // Bit writes are read-modify-write; a bit write to RAM is taken as a byte
   // write of the merged value, so the CPU must supply the merged byte.
   assign ram_we = dreq_i.valid & dreq_i.write & to_ram;
   assign ram_wdata = dreq_i.wdata;

   // Read data registered, one cycle behind the address
   msd_ram u_ram (
      .core_clk_i(core_clk_i),
      .we_i(ram_we),
      .addr_i(ram_addr),
      .wdata_i(ram_wdata),
      .rdata_o(ram_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Status word shadow

   // Only the bank bits are used; the core keeps the whole word
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         status_reg <= `MSD_STATUS_RESET;
      end else if (dreq_i.valid & dreq_i.write & to_sfr
                   & (dreq_i.addr == `MSD_SFR_STATUS)) begin
         status_reg <= dreq_i.wdata;
      end
   end

   // Bank output lags the status write by one cycle
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         bank_o <= 2'b00;
      end else begin
         bank_o <= status_reg[4:3];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Special register port and read return

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         sfr_sel_o <= 1'b0;
         sfr_we_o <= 1'b0;
         sfr_addr_o <= 8'h00;
         sfr_wdata_o <= 8'h00;
         xdata_nack_o <= 1'b0;
      end else begin
         sfr_sel_o <= dreq_i.valid & to_sfr;
         sfr_we_o <= dreq_i.valid & dreq_i.write & to_sfr;
         sfr_addr_o <= dreq_i.addr;
         sfr_wdata_o <= dreq_i.wdata;
         // No expansion data memory: every external move is refused
         xdata_nack_o <= xdata_req_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         sfr_hit_reg <= 1'b0;
         bitpos_reg <= 3'b000;
         bitmode_reg <= 1'b0;
         rvalid_o <= 1'b0;
      end else begin
         sfr_hit_reg <= to_sfr;
         bitpos_reg <= (dreq_i.addr > `MSD_LOW_TOP) ? bit_sel_i : dreq_i.addr[2:0];
         bitmode_reg <= dreq_i.mode == msd_pkg::MSD_MODE_BIT;
         rvalid_o <= dreq_i.valid & ~dreq_i.write & (to_sfr | to_ram);
      end
   end

   // Read data lands one cycle after rvalid; SFR bit uses bit_sel_i
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rdata_o <= 8'h00;
         bit_rdata_o <= 1'b0;
      end else begin
         rdata_o <= sfr_hit_reg ? sfr_rdata_i : ram_rdata;
         bit_rdata_o <= bitmode_reg & (sfr_hit_reg ? sfr_rdata_i[bitpos_reg]
                                                    : ram_rdata[bitpos_reg]);
      end
   end
endmodule

/* logic/msd_params.svh */
// Constants for the memory space decoder
`ifndef MSD_PARAMS_SVH
`define MSD_PARAMS_SVH
`define MSD_RESET_VECTOR 16'h0000
`define MSD_VEC_EXT0 16'h0003
`define MSD_VEC_TMR0 16'h000B
`define MSD_VEC_EXT1 16'h0013
`define MSD_VEC_TMR1 16'h001B
`define MSD_VEC_SPACING 16'h0008
`define MSD_CODE_BYTES 8192
`define MSD_CODE_MASK 16'h1FFF
`define MSD_RAM_BYTES 256
`define MSD_LOW_TOP 8'h7F
`define MSD_BANK_BYTES 8'h08
`define MSD_BIT_BASE 8'h20
`define MSD_SFR_STATUS 8'hD0
`define MSD_BANK_HI_POS 4
`define MSD_BANK_LO_POS 3
`define MSD_SFR_BITADR_MASK 8'h07
`define MSD_STATUS_RESET 8'h00
`endif

/* logic/msd_pkg.sv */
// Types for the memory space decoder
package msd_pkg;
   typedef enum logic [1:0] {
      MSD_MODE_DIRECT,
      MSD_MODE_INDIRECT,
      MSD_MODE_REGISTER,
      MSD_MODE_BIT
   } msd_mode_e;

   typedef enum logic [2:0] {
      MSD_TGT_NONE,
      MSD_TGT_RAM,
      MSD_TGT_SFR,
      MSD_TGT_CODE
   } msd_tgt_e;

   typedef struct packed {
      logic valid;
      logic write;
      msd_mode_e mode;
      logic [7:0] addr;
      logic [7:0] wdata;
   } msd_dreq_s;

   typedef struct packed {
      logic valid;
      logic is_int;
      logic [1:0] int_src;
      logic is_indexed;
      logic [15:0] addr;
   } msd_creq_s;
endpackage

/* logic/msd_ram.sv */
// Internal 256 byte data RAM with registered read port
`timescale 1ns/1ps
module msd_ram (
   // Clock
   input wire logic core_clk_i,
   // Access
   input wire logic we_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o
);
   logic [7:0] mem_reg [0:255];

   always_ff @(posedge core_clk_i) begin
      if (we_i) begin
         mem_reg[addr_i] <= wdata_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      rdata_o <= mem_reg[addr_i];
   end
endmodule

/* tb/msd_decode_assertions.sv */
// Port checker for the memory space decoder
`timescale 1ns/1ps
module msd_chk (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Program side
   input wire msd_pkg::msd_creq_s creq_i,
   input wire logic [7:0] acc_i,
   input wire logic [15:0] data_pointer_16_i,
   input wire logic [12:0] code_addr_o,
   input wire logic code_rd_o,
   // Data side
   input wire msd_pkg::msd_dreq_s dreq_i,
   input wire logic xdata_req_i,
   input wire logic rvalid_o,
   input wire logic sfr_sel_o,
   input wire logic [7:0] sfr_addr_o,
   input wire logic xdata_nack_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   // A plain first fetch after reset ignores its address
   logic boot_seen_reg;
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         boot_seen_reg <= 1'b1;
      end else if (creq_i.valid) begin
         boot_seen_reg <= 1'b0;
      end
   end
   a_fetch_strobe: assert property (creq_i.valid |=> code_rd_o) else $error("no strobe");
   a_int_vector: assert property (creq_i.valid && creq_i.is_int |=>
      code_addr_o == 13'h0003 + 13'({$past(creq_i.int_src), 3'h0})) else $error("bad vector");
   a_index_read: assert property (creq_i.valid && !creq_i.is_int && creq_i.is_indexed |=>
      code_addr_o == 13'($past(data_pointer_16_i) + 16'($past(acc_i)))) else $error("bad index");
   a_plain_fetch: assert property (!boot_seen_reg && creq_i.valid && !creq_i.is_int &&
      !creq_i.is_indexed |=> code_addr_o == $past(creq_i.addr[12:0])) else $error("bad fetch");
   a_boot_fetch: assert property (boot_seen_reg && creq_i.valid && !creq_i.is_int &&
      !creq_i.is_indexed |=> code_addr_o == 13'h0000) else $error("first fetch not at zero");
   a_direct_sfr: assert property (dreq_i.valid && dreq_i.mode == 0 && dreq_i.addr[7] |=>
      sfr_sel_o && sfr_addr_o == $past(dreq_i.addr)) else $error("no sfr");
   a_indirect_ram: assert property (dreq_i.valid && dreq_i.mode == 1 |=> !sfr_sel_o)
      else $error("indirect hit sfr");
   a_low_ram: assert property (dreq_i.valid && dreq_i.mode == 0 && !dreq_i.addr[7] |=>
      !sfr_sel_o) else $error("low hit sfr");
   a_read_valid: assert property (dreq_i.valid && !dreq_i.write && dreq_i.mode != 3 |=>
      rvalid_o) else $error("no rvalid");
   a_xdata_nack: assert property (xdata_req_i |=> xdata_nack_o) else $error("no nack");
   a_bit_sfr: assert property (dreq_i.valid && dreq_i.mode == 3 &&
      dreq_i.addr[7] && dreq_i.addr[2:0] == 3'h0 |=> sfr_sel_o) else $error("no sfr bit");
   a_bit_unaligned: assert property (dreq_i.valid && dreq_i.mode == 3 &&
      dreq_i.addr[7] && dreq_i.addr[2:0] != 3'h0 |=> !sfr_sel_o && !rvalid_o)
      else $error("unaligned bit hit");
endmodule
bind msd_decode msd_chk u_chk (.core_clk_i, .rst_i, .creq_i, .acc_i, .data_pointer_16_i,
   .code_addr_o, .code_rd_o, .dreq_i, .xdata_req_i, .rvalid_o, .sfr_sel_o, .sfr_addr_o,
   .xdata_nack_o);

/* tb/msd_sfr_model.sv */
// Special register responder on the decoder's register port
`timescale 1ns/1ps
module msd_sfr_model (
   // Clock
   input wire logic core_clk_i,
   // Register port
   input wire logic sfr_sel_i,
   input wire logic sfr_we_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o
);
   logic [7:0] mem_reg [256];
   logic [7:0] addr_reg = 8'h00;
   logic held_reg = 1'b0;
   always_ff @(posedge core_clk_i) begin
      if (sfr_sel_i && sfr_we_i) mem_reg[addr_i] <= wdata_i;
      if (sfr_sel_i) addr_reg <= addr_i;
      held_reg <= sfr_sel_i;
   end
   // Outside the answer window show inverted data, so stale bytes never match
   assign rdata_o = (sfr_sel_i || held_reg) ? mem_reg[sfr_sel_i ? addr_i : addr_reg] :
      ~mem_reg[addr_reg];
endmodule

/* tb/testbench.sv */
// Self-checking bench for the memory space decoder
`include "msd_params.svh"
`timescale 1ns/1ps
module testbench;
   localparam msd_pkg::msd_mode_e DIR = msd_pkg::MSD_MODE_DIRECT;
   localparam msd_pkg::msd_mode_e IND = msd_pkg::MSD_MODE_INDIRECT;
   localparam msd_pkg::msd_mode_e BIT = msd_pkg::MSD_MODE_BIT;
   logic core_clk_i = 0;
   logic rst_i = 1;
   msd_pkg::msd_creq_s creq = '0;
   msd_pkg::msd_dreq_s dreq = '0;
   logic [7:0] acc = 8'h00, rdata, sfr_rd, sfr_a, sfr_wd, ra;
   logic [15:0] dp = 16'h0000, a16;
   logic [12:0] caddr;
   logic xreq = 0, crd, rv, brd, ssel, swe, xnack;
   logic [2:0] bsel = 3'h0;
   logic [1:0] bank;
   logic [31:0] seed = 32'd92;
   int fail_count = 0, total_checks = 0, cyc = 0;
   always #5 core_clk_i = ~core_clk_i;
   msd_decode u_msd_decode (.core_clk_i, .rst_i, .creq_i(creq), .acc_i(acc),
      .data_pointer_16_i(dp), .code_addr_o(caddr), .code_rd_o(crd), .dreq_i(dreq),
      .bit_sel_i(bsel), .xdata_req_i(xreq), .rdata_o(rdata), .rvalid_o(rv),
      .bit_rdata_o(brd), .sfr_sel_o(ssel), .sfr_we_o(swe), .sfr_addr_o(sfr_a),
      .sfr_wdata_o(sfr_wd), .sfr_rdata_i(sfr_rd), .xdata_nack_o(xnack), .bank_o(bank));
   msd_sfr_model u_msd_sfr_model (.core_clk_i, .sfr_sel_i(ssel), .sfr_we_i(swe),
      .addr_i(sfr_a), .wdata_i(sfr_wd), .rdata_o(sfr_rd));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(logic [15:0] got, logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic fetch(logic i, logic [1:0] s, logic x, logic [15:0] a, logic [12:0] e);
      @(negedge core_clk_i) creq = '{1'b1, i, s, x, a};
      @(negedge core_clk_i) creq.valid = 0;
      chk(crd, 1);
      chk(caddr, e);
   endtask
   task automatic dacc(logic w, msd_pkg::msd_mode_e m, logic [7:0] a, logic [7:0] d);
      @(negedge core_clk_i) dreq = '{1'b1, w, m, a, d};
      @(negedge core_clk_i) dreq.valid = 0;
   endtask
   task automatic rd(msd_pkg::msd_mode_e m, logic [7:0] a, logic [7:0] e);
      dacc(0, m, a, 8'h00);
      if (m != msd_pkg::MSD_MODE_BIT) chk(rv, 1);
      @(negedge core_clk_i);
      chk(m == msd_pkg::MSD_MODE_BIT ? {7'h0, brd} : rdata, e);
   endtask
   task automatic summarize();
      if (fail_count == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         summarize();
      end
   end
   initial begin
      repeat (5) @(negedge core_clk_i);
      rst_i = 0;
      fetch(0, 0, 0, 16'h0ABC, 13'(`MSD_RESET_VECTOR));
      for (int i = 0; i < 4; i++) fetch(1, 2'(i), 0, 16'h1234, 13'(3 + 8 * i));
      for (int i = 0; i < 20; i++) begin
         a16 = 16'(rnd());
         acc = 8'(rnd());
         dp = 16'(rnd());
         ra = {1'b1, a16[6:0]};
         fetch(0, 0, 0, a16, a16[12:0]);
         fetch(0, 0, 1, a16, 13'(dp + 16'(acc)));
         dacc(1, IND, ra, a16[15:8]);
         dacc(1, DIR, ra, ~a16[15:8]);
         rd(IND, ra, a16[15:8]);
         rd(DIR, ra, ~a16[15:8]);
         dacc(1, DIR, {1'b0, ra[6:0]}, acc);
         rd(IND, {1'b0, ra[6:0]}, acc);
      end
      for (int b = 0; b < 4; b++) begin
         dacc(1, DIR, `MSD_SFR_STATUS, 8'(b << 3));
         dacc(1, msd_pkg::MSD_MODE_REGISTER, 8'h05, 8'(8'hA0 + b));
         chk(bank, 16'(b));
         rd(DIR, 8'(b * 8 + 5), 8'(8'hA0 + b));
      end
      dacc(1, DIR, 8'h2C, 8'h5A);
      for (int j = 0; j < 8; j++) rd(BIT, 8'(8'h60 + j), 8'((8'h5A >> j) & 1));
      dacc(1, DIR, 8'hA8, 8'hC3);
      for (int j = 0; j < 8; j++) begin
         bsel = 3'(j);
         rd(BIT, 8'hA8, 8'((8'hC3 >> j) & 1));
      end
      dacc(0, BIT, 8'hA9, 8'h00);
      chk(rv, 0);
      chk(ssel, 0);
      @(negedge core_clk_i) rst_i = 1;
      repeat (2) @(negedge core_clk_i);
      chk(crd, 0);
      chk(rv, 0);
      chk(bank, 0);
      rst_i = 0;
      fetch(0, 0, 0, 16'h1555, 13'(`MSD_RESET_VECTOR));
      rd(msd_pkg::MSD_MODE_REGISTER, 8'h05, 8'hA0);
      @(negedge core_clk_i) xreq = 1;
      @(negedge core_clk_i) xreq = 0;
      chk(xnack, 1);
      @(negedge core_clk_i);
      chk(xnack, 0);
      summarize();
   end
endmodule
